// ===== hdl/tmdcd_pkg.sv
// constants shared by the trigger mask and dac command decoder
package tmdcd_pkg;
   // command identifiers
   localparam logic [15:0] CMD_MASK_LO_SET = 16'h2205;
   localparam logic [15:0] CMD_MASK_HI_SET = 16'h2206;
   localparam logic [15:0] CMD_MASK_LO_RD = 16'h2207;
   localparam logic [15:0] CMD_MASK_HI_RD = 16'h2208;
   localparam logic [15:0] CMD_FIFO_CLR = 16'h2209;
   localparam logic [15:0] CMD_SAW = 16'h2400;
   localparam logic [15:0] CMD_DAC_INIT = 16'h2401;
   localparam logic [15:0] CMD_DAC_SET = 16'h2402;
   // response id flag and own unit address
   localparam logic [15:0] RSP_FLAG = 16'h8000;
   localparam logic [15:0] UNIT_ADDR = 16'h4000;
   // board field
   localparam int BRD_HI = 31;
   localparam int BRD_LO = 28;
   localparam int NUM_BOARDS = 8;
   localparam logic [3:0] BRD_ALL = 4'h8;
   localparam logic [3:0] BRD_BAD = 4'hf;
   // response payloads for errors and the gap bits of a mask read
   localparam logic [31:0] PAY_ONES = 32'hffffffff;
   localparam logic [31:0] PAY_BADBRD = 32'hf0000000;
   localparam logic [15:0] VOLT_BAD = 16'hffff;
   localparam logic [11:0] PAY_GAP = 12'h000;
   // mask, hold and wave count fields
   localparam int MASK_W = 16;
   localparam int HOLD_W = 8;
   localparam int NUM_HOLDS = 3;
   localparam int CNT_W = 16;
   // dac set fields
   localparam int TYPE_HI = 22;
   localparam int TYPE_LO = 21;
   localparam int ALLCH_BIT = 20;
   localparam int CHAN_HI = 19;
   localparam int CHAN_LO = 16;
   localparam logic [1:0] TYPE_ENERGY = 2'h0;
   localparam logic [1:0] TYPE_ALL = 2'h3;
   localparam logic [3:0] CHAN_NONE = 4'h0;
   // decimal voltage digits, millivolt weights and limits
   localparam logic [3:0] MAX_UNIT = 4'h4;
   localparam logic [3:0] MAX_DIGIT = 4'h9;
   localparam logic [15:0] W_UNIT = 16'h03e8;
   localparam logic [15:0] W_TENTH = 16'h0064;
   localparam logic [15:0] W_HUND = 16'h000a;
   localparam logic [15:0] LIM_ENERGY = 16'h0ff0;
   localparam logic [15:0] LIM_OTHER = 16'h09ce;
   // wishbone register byte addresses
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_TGT = 8'h04;
   localparam logic [7:0] REG_PAY = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0c;
   localparam logic [7:0] REG_RSP_ID = 8'h10;
   localparam logic [7:0] REG_RSP_TGT = 8'h14;
   localparam logic [7:0] REG_RSP_PAY = 8'h18;
   // control and status bits
   localparam int CTRL_GO = 0;
   localparam int CTRL_CLR = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ERR = 2;
   // timing
   localparam int CLK_NS = 4;
   localparam int MS_NS = 1000000;
   localparam int WAVE_MS = 1800;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
   localparam int unsigned WAVE_CYCLES = WAVE_MS * MS_CYCLES;
endpackage : tmdcd_pkg

// ===== hdl/tmdcd_hold.sv
// reset hold timer counting whole milliseconds
`timescale 1ns/10ps
`default_nettype none
module tmdcd_hold #(
   parameter int unsigned MS_CYC = 250000
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] ms,
   output var logic hold_q
);
   logic [31:0] pre_q; // cycles left in this millisecond
   logic [7:0] left_q; // milliseconds left

   // zero length never asserts the hold
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_q <= 1'b0;
         pre_q <= 32'h0;
         left_q <= 8'h0;
      end else if (start && ms != 8'h0) begin
         hold_q <= 1'b1;
         left_q <= ms;
         pre_q <= 32'(MS_CYC - 1);
      end else if (hold_q) begin
         if (pre_q != 32'h0) begin
            pre_q <= pre_q - 32'h1;
         end else if (left_q == 8'h1) begin
            hold_q <= 1'b0; // last millisecond over
            left_q <= 8'h0;
         end else begin
            left_q <= left_q - 8'h1;
            pre_q <= 32'(MS_CYC - 1);
         end
      end
   end
endmodule : tmdcd_hold
`default_nettype wire

// ===== hdl/tmdcd_saw.sv
// sawtooth test pulse sequencer, one wave per period
`timescale 1ns/10ps
`default_nettype none
module tmdcd_saw #(
   parameter int unsigned PERIOD = 450000000
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [15:0] waves,
   output var logic active_q,
   output var logic wave_q
);
   logic [31:0] ph_q; // cycles left in current wave
   logic [15:0] left_q; // waves still to send

   // a new start with a nonzero wave count restarts the sequence
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         active_q <= 1'b0;
         wave_q <= 1'b0;
         ph_q <= 32'h0;
         left_q <= 16'h0;
      end else begin
         wave_q <= 1'b0;
         if (start && waves != 16'h0) begin
            active_q <= 1'b1;
            wave_q <= 1'b1;
            left_q <= waves;
            ph_q <= 32'(PERIOD - 1);
         end else if (active_q) begin
            if (ph_q != 32'h0) begin
               ph_q <= ph_q - 32'h1;
            end else if (left_q == 16'h1) begin
               active_q <= 1'b0; // last wave done
               left_q <= 16'h0;
            end else begin
               left_q <= left_q - 16'h1;
               wave_q <= 1'b1; // next ramp begins
               ph_q <= 32'(PERIOD - 1);
            end
         end
      end
   end
endmodule : tmdcd_saw
`default_nettype wire

// ===== hdl/tmdcd_top.sv
// command decoder for trigger masks, fifo clear, test pulse and dacs
// Operation
// - 0x2205: board in 31-28, channels 0-15 enables
// - 0x2206: same layout, channels 16-31 enables
// - set success echoes payload with response id
// - bad board address: response bits 31-28 ones
// - 0x2207 reads low mask, board echoed
// - 0x2208 reads high mask, board echoed
// - board copy mismatch returns all ones
// - read of bad board returns 0xf0000000
// - 0x2209 holds three resets for given milliseconds
// - all hold fields zero: nothing cleared
// - 0x2400 sends counted 1.8 s sawtooth waves
// - 0x2401 initialises dacs, board 8 means all
// - bits 27-25 reserved and ignored
// - 0x2402 decodes dac type, all-channel, channel
// - voltage is four decimal digits
// - out of range voltage ignored, bits 15-0 ones
// - dac type 3 ignores channel fields
// - command has id, target address, payload
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tmdcd_top #(
   parameter int unsigned MS_CYC = tmdcd_pkg::MS_CYCLES,
   parameter int unsigned WAVE_CYC = tmdcd_pkg::WAVE_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output var logic [31:0] wb_dat_o,
   output var logic wb_ack_o,
   output var logic [7:0] db_mask_wr,
   output var logic db_mask_hi,
   output var logic [15:0] db_mask_data,
   output var logic [2:0] db_rd_sel,
   output var logic db_rd_hi,
   input wire logic [15:0] db_rd_mask,
   output wire logic hold_board,
   output wire logic hold_io,
   output wire logic hold_main,
   output wire logic saw_active,
   output wire logic saw_wave,
   output var logic [2:0] saw_board,
   output var logic [7:0] dac_init,
   output var logic dac_set,
   output var logic [2:0] dac_board,
   output var logic [1:0] dac_type,
   output var logic dac_all_ch,
   output var logic [3:0] dac_chan,
   output var logic [15:0] dac_code
);
   import tmdcd_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_READ} tmdcd_state_e;

   tmdcd_state_e st_q; // sequencer state
   logic [15:0] cmd_q; // command id
   logic [15:0] tgt_q; // target address
   logic [31:0] pay_q; // command payload
   logic [15:0] rsp_id_q; // response id
   logic [15:0] rsp_tgt_q; // response target
   logic [31:0] rsp_pay_q; // response payload
   logic done_q; // response ready, sticky
   logic err_q; // bad target or unknown command
   logic [31:0] mask_q [NUM_BOARDS]; // controller copy of masks
   logic [NUM_BOARDS-1:0] hit; // boards named by payload
   logic [NUM_HOLDS-1:0] hold_start; // per field hold start
   logic [NUM_HOLDS-1:0] hold; // hold levels
   logic req, wr, go, clr;
   logic [3:0] brd;
   logic single_ok, brd_ok, tgt_ok, known, is_read, is_mask_set;
   logic volt_ok, act, fin, mismatch;
   logic [15:0] mv, lim, copy;
   logic [31:0] rsp_d, rd_d;
   logic [31:0] cmd_m, tgt_m; // lane merged command and target words

   // byte lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // merged words, upper halves of the 16-bit registers unused
   assign cmd_m = merge({16'h0, cmd_q}, wb_dat_i, wb_sel_i);
   assign tgt_m = merge({16'h0, tgt_q}, wb_dat_i, wb_sel_i);

   // bus request phase and write edge (the edge that sees ack)
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign go = wr && wb_adr_i == REG_CTRL && wb_sel_i[0]
      && wb_dat_i[CTRL_GO] && st_q == ST_IDLE;
   assign clr = wr && wb_adr_i == REG_CTRL && wb_sel_i[0]
      && wb_dat_i[CTRL_CLR];

   // one-cycle ack for every access, mapped or not
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rd_d;
         end
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      rd_d = 32'h0;
      if (wb_adr_i == REG_CMD) begin
         rd_d[15:0] = cmd_q;
      end else if (wb_adr_i == REG_TGT) begin
         rd_d[15:0] = tgt_q;
      end else if (wb_adr_i == REG_PAY) begin
         rd_d = pay_q;
      end else if (wb_adr_i == REG_CTRL) begin
         rd_d[STAT_BUSY] = st_q != ST_IDLE;
         rd_d[STAT_DONE] = done_q;
         rd_d[STAT_ERR] = err_q;
      end else if (wb_adr_i == REG_RSP_ID) begin
         rd_d[15:0] = rsp_id_q;
      end else if (wb_adr_i == REG_RSP_TGT) begin
         rd_d[15:0] = rsp_tgt_q;
      end else if (wb_adr_i == REG_RSP_PAY) begin
         rd_d = rsp_pay_q;
      end
   end

   // command registers, frozen while a command runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_q <= 16'h0;
         tgt_q <= 16'h0;
         pay_q <= 32'h0;
      end else if (wr && st_q == ST_IDLE) begin
         if (wb_adr_i == REG_CMD) begin
            cmd_q <= cmd_m[15:0];
         end else if (wb_adr_i == REG_TGT) begin
            tgt_q <= tgt_m[15:0];
         end else if (wb_adr_i == REG_PAY) begin
            pay_q <= merge(pay_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // payload decode; bits 27-25 never looked at
   assign brd = pay_q[BRD_HI:BRD_LO];
   assign single_ok = brd < BRD_ALL;
   assign is_mask_set = cmd_q == CMD_MASK_LO_SET
      || cmd_q == CMD_MASK_HI_SET;
   assign is_read = cmd_q == CMD_MASK_LO_RD || cmd_q == CMD_MASK_HI_RD;
   assign known = is_mask_set || is_read || cmd_q == CMD_FIFO_CLR
      || cmd_q == CMD_SAW || cmd_q == CMD_DAC_INIT
      || cmd_q == CMD_DAC_SET;
   // board 8 allowed only where all boards may be named
   assign brd_ok = (is_mask_set || cmd_q == CMD_DAC_INIT)
      ? (single_ok || brd == BRD_ALL) : single_ok;
   assign tgt_ok = tgt_q == UNIT_ADDR;

   // boards selected by the address field
   generate
      for (genvar b = 0; b < NUM_BOARDS; b++) begin : g_hit
         assign hit[b] = brd == BRD_ALL || brd == 4'(b);
      end
   endgenerate

   // decimal millivolts and range check
   assign mv = pay_q[15:12] * W_UNIT + pay_q[11:8] * W_TENTH
      + pay_q[7:4] * W_HUND + {12'h0, pay_q[3:0]};
   assign lim = pay_q[TYPE_HI:TYPE_LO] == TYPE_ENERGY
      ? LIM_ENERGY : LIM_OTHER;
   assign volt_ok = pay_q[15:12] <= MAX_UNIT && pay_q[11:8] <= MAX_DIGIT
      && pay_q[7:4] <= MAX_DIGIT && pay_q[3:0] <= MAX_DIGIT
      && mv <= lim;

   // action strobe and finish of a command
   assign act = st_q == ST_EXEC && tgt_ok && brd_ok && !is_read;
   assign fin = (st_q == ST_EXEC && !(is_read && brd_ok && tgt_ok))
      || st_q == ST_READ;
   assign copy = cmd_q == CMD_MASK_HI_RD ? mask_q[brd[2:0]][31:16]
      : mask_q[brd[2:0]][15:0];
   assign mismatch = db_rd_mask != copy;

   // response payload
   always_comb begin
      rsp_d = pay_q; // echo by default
      if (is_read && !brd_ok) begin
         rsp_d = PAY_BADBRD;
      end else if (st_q == ST_READ && mismatch) begin
         rsp_d = PAY_ONES;
      end else if (st_q == ST_READ) begin
         rsp_d = {brd, PAY_GAP, copy};
      end else begin
         if (known && !brd_ok) begin
            rsp_d[BRD_HI:BRD_LO] = BRD_BAD;
         end
         if (cmd_q == CMD_DAC_SET && !volt_ok) begin
            rsp_d[15:0] = VOLT_BAD;
         end
      end
   end

   // sequencer: idle, execute, wait one cycle for board readback
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: if (go) st_q <= ST_EXEC;
            ST_EXEC: st_q <= fin ? ST_IDLE : ST_READ;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // readback select toward the boards
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         db_rd_sel <= 3'h0;
         db_rd_hi <= 1'b0;
      end else if (st_q == ST_EXEC && is_read) begin
         db_rd_sel <= brd[2:0];
         db_rd_hi <= cmd_q == CMD_MASK_HI_RD;
      end
   end

   // response registers and status flags; a new done wins over clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_id_q <= 16'h0;
         rsp_tgt_q <= 16'h0;
         rsp_pay_q <= 32'h0;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         if (fin) begin
            rsp_id_q <= cmd_q | RSP_FLAG;
            rsp_tgt_q <= tgt_q;
            rsp_pay_q <= rsp_d;
            err_q <= !tgt_ok || !known;
         end
         if (fin) begin
            done_q <= 1'b1;
         end else if (clr) begin
            done_q <= 1'b0;
         end
      end
   end

   // controller mask copy and writes toward the boards
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < NUM_BOARDS; b++) begin
            mask_q[b] <= 32'h0;
         end
         db_mask_wr <= 8'h0;
         db_mask_hi <= 1'b0;
         db_mask_data <= 16'h0;
      end else begin
         db_mask_wr <= 8'h0;
         if (act && is_mask_set) begin
            db_mask_wr <= hit;
            db_mask_hi <= cmd_q == CMD_MASK_HI_SET;
            db_mask_data <= pay_q[MASK_W-1:0];
            for (int b = 0; b < NUM_BOARDS; b++) begin
               if (hit[b] && cmd_q == CMD_MASK_HI_SET) begin
                  mask_q[b][31:16] <= pay_q[MASK_W-1:0];
               end else if (hit[b]) begin
                  mask_q[b][15:0] <= pay_q[MASK_W-1:0];
               end
            end
         end
      end
   end

   // reset hold timers: field 0 main, 1 io, 2 board
   generate
      for (genvar h = 0; h < NUM_HOLDS; h++) begin : g_hold
         assign hold_start[h] = act && cmd_q == CMD_FIFO_CLR;
         tmdcd_hold #(.MS_CYC(MS_CYC)) u_hold (
            .clock(clock),
            .rst(rst),
            .start(hold_start[h]),
            .ms(pay_q[h*HOLD_W +: HOLD_W]),
            .hold_q(hold[h])
         );
      end
   endgenerate
   assign hold_main = hold[0];
   assign hold_io = hold[1];
   assign hold_board = hold[2];

   // sawtooth test pulse sequencer
   tmdcd_saw #(.PERIOD(WAVE_CYC)) u_saw (
      .clock(clock),
      .rst(rst),
      .start(act && cmd_q == CMD_SAW),
      .waves(pay_q[CNT_W-1:0]),
      .active_q(saw_active),
      .wave_q(saw_wave)
   );

   // dac init, dac set and test pulse board outputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dac_init <= 8'h0;
         dac_set <= 1'b0;
         dac_board <= 3'h0;
         dac_type <= 2'h0;
         dac_all_ch <= 1'b0;
         dac_chan <= 4'h0;
         dac_code <= 16'h0;
         saw_board <= 3'h0;
      end else begin
         dac_init <= 8'h0;
         dac_set <= 1'b0;
         if (act && cmd_q == CMD_SAW) begin
            saw_board <= brd[2:0];
         end
         if (act && cmd_q == CMD_DAC_INIT) begin
            dac_init <= hit;
         end
         if (act && cmd_q == CMD_DAC_SET && volt_ok) begin
            dac_set <= 1'b1;
            dac_board <= brd[2:0];
            dac_type <= pay_q[TYPE_HI:TYPE_LO];
            dac_code <= pay_q[15:0];
            if (pay_q[TYPE_HI:TYPE_LO] == TYPE_ALL) begin
               dac_all_ch <= 1'b1;
               dac_chan <= CHAN_NONE;
            end else begin
               dac_all_ch <= pay_q[ALLCH_BIT];
               dac_chan <= pay_q[CHAN_HI:CHAN_LO];
            end
         end
      end
   end

   property p_rsp_id;
      @(posedge clock) disable iff (rst)
      fin |=> rsp_id_q[15] && rsp_id_q[14:0] == $past(cmd_q[14:0]);
   endproperty
   a_rsp_id: assert property (p_rsp_id)
      else $error("response id not command id with bit 15");

   property p_echo;
      @(posedge clock) disable iff (rst)
      act && is_mask_set |=> done_q && rsp_pay_q == $past(pay_q);
   endproperty
   a_echo: assert property (p_echo)
      else $error("set response does not echo payload");

   property p_bad_brd;
      @(posedge clock) disable iff (rst)
      fin && known && !is_read && !brd_ok |=> rsp_pay_q[31:28] == 4'hf;
   endproperty
   a_bad_brd: assert property (p_bad_brd)
      else $error("bad board not flagged");

   property p_rd_bad;
      @(posedge clock) disable iff (rst)
      st_q == ST_EXEC && tgt_ok && is_read && !brd_ok
      |=> rsp_pay_q == 32'hf0000000 && st_q == ST_IDLE;
   endproperty
   a_rd_bad: assert property (p_rd_bad)
      else $error("bad board read payload wrong");

   property p_rd_miss;
      @(posedge clock) disable iff (rst)
      st_q == ST_READ && db_rd_mask != copy |=> rsp_pay_q == 32'hffffffff;
   endproperty
   a_rd_miss: assert property (p_rd_miss)
      else $error("mask mismatch not reported");

   property p_rd_ok;
      @(posedge clock) disable iff (rst)
      st_q == ST_EXEC && tgt_ok && is_read && brd_ok
      ##1 db_rd_mask == copy |=> rsp_pay_q[15:0] == $past(db_rd_mask)
      && rsp_pay_q[31:28] == $past(brd, 2);
   endproperty
   a_rd_ok: assert property (p_rd_ok)
      else $error("mask read payload wrong");

   property p_lo_set;
      @(posedge clock) disable iff (rst)
      act && cmd_q == CMD_MASK_LO_SET && hit[3]
      |=> mask_q[3][15:0] == $past(pay_q[15:0]) && db_mask_wr[3];
   endproperty
   a_lo_set: assert property (p_lo_set)
      else $error("low mask not stored");

   property p_volt;
      @(posedge clock) disable iff (rst)
      act && cmd_q == CMD_DAC_SET && !volt_ok
      |=> !dac_set && rsp_pay_q[15:0] == 16'hffff;
   endproperty
   a_volt: assert property (p_volt)
      else $error("bad voltage not ignored");

   property p_no_clr;
      @(posedge clock) disable iff (rst)
      act && cmd_q == CMD_FIFO_CLR && pay_q[23:0] == 24'h0 && hold == 3'h0
      |=> ##1 hold == 3'h0;
   endproperty
   a_no_clr: assert property (p_no_clr)
      else $error("zero hold still cleared fifo");

   property p_hold;
      @(posedge clock) disable iff (rst)
      act && cmd_q == CMD_FIFO_CLR && pay_q[7:0] != 8'h0
      |=> hold_main [*2];
   endproperty
   a_hold: assert property (p_hold)
      else $error("main reset hold not started");
endmodule : tmdcd_top
`default_nettype wire

// ===== test/tmdcd_board_model.sv
// detector board mask store answering readback requests
`timescale 1ns/10ps
`default_nettype none
module tmdcd_board_model (
   input wire logic clock,
   input wire logic [7:0] db_mask_wr,
   input wire logic db_mask_hi,
   input wire logic [15:0] db_mask_data,
   input wire logic [2:0] db_rd_sel,
   input wire logic db_rd_hi,
   input wire logic upset,
   output logic [15:0] db_rd_mask
);
   logic [15:0] mem [16]; // masks indexed by half and board
   // keep each board's half on its write strobe
   always @(posedge clock) begin
      for (int b = 0; b < 8; b++) begin
         if (db_mask_wr[b]) begin
            mem[{db_mask_hi, 3'(b)}] <= db_mask_data;
         end
      end
   end
   // readback, low bit flipped when told to disagree
   assign db_rd_mask = mem[{db_rd_hi, db_rd_sel}]
      ^ {15'h0, upset};
endmodule : tmdcd_board_model
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
   import tmdcd_pkg::*;
   logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, upset;
   logic [7:0] wb_adr_i, db_mask_wr, dac_init, ini_q;
   logic [3:0] wb_sel_i, dac_chan, chan_q;
   logic [31:0] wb_dat_i, wb_dat_o, seed;
   logic hold_board, hold_io, hold_main, saw_active, saw_wave, db_mask_hi;
   logic db_rd_hi, dac_set, dac_all_ch, all_q;
   logic [18:0] code_q; // last dac board and code seen with dac_set
   logic [15:0] db_mask_data, db_rd_mask, dac_code;
   logic [2:0] db_rd_sel, saw_board, dac_board;
   logic [1:0] dac_type, type_q;
   logic [17:0] vt [6] = '{18'h04080, 18'h04081, 18'h12510, 18'h22511,
      18'h05000, 18'h0100a}; // type and voltage digits
   int err_total, checks_done, cyc_n, hb, hi, hm, nw, na;
   int lo_m [8], hi_m [8]; // expected board masks
   tmdcd_top #(.MS_CYC(4), .WAVE_CYC(8)) i_tmdcd_top (.clock, .rst,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .db_mask_wr, .db_mask_hi, .db_mask_data,
      .db_rd_sel, .db_rd_hi, .db_rd_mask, .hold_board, .hold_io, .hold_main,
      .saw_active, .saw_wave, .saw_board, .dac_init, .dac_set, .dac_board,
      .dac_type, .dac_all_ch, .dac_chan, .dac_code);
   tmdcd_board_model i_tmdcd_board_model (.clock, .db_mask_wr, .db_mask_hi,
      .db_mask_data, .db_rd_sel, .db_rd_hi, .upset, .db_rd_mask);
   // clock, 4 ns period
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   // tally action outputs and cut a hang short
   always @(posedge clock) begin
      cyc_n++;
      hb += hold_board;
      hi += hold_io;
      hm += hold_main;
      nw += saw_wave;
      na += saw_active;
      if (|dac_init) ini_q <= dac_init;
      if (dac_set) begin
         all_q <= dac_all_ch;
         chan_q <= dac_chan;
         type_q <= dac_type;
         code_q <= {dac_board, dac_code};
      end
      if (cyc_n == 40000) begin
         err_total++;
         give_verdict();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // expected payload for echoing commands
   function automatic logic [31:0] ep(input logic [15:0] id,
      input logic [31:0] p);
      int v;
      logic [31:0] r;
      r = p;
      v = p[15:12] * 1000 + p[11:8] * 100 + p[7:4] * 10 + p[3:0];
      if (p[31:28] > ((id == CMD_SAW || id == CMD_DAC_SET) ? 7 : 8))
         r[31:28] = 4'hf;
      if (id == CMD_DAC_SET && (v > (p[22:21] == 0 ? 4080 : 2510) ||
         p[15:12] > 4 || p[11:8] > 9 || p[7:4] > 9 || p[3:0] > 9))
         r[15:0] = 16'hffff;
      return r;
   endfunction : ep
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one classic wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask : wb
   // issue a command, wait for done, check the response
   task automatic run(input logic [15:0] id, input logic [15:0] tg,
      input logic [31:0] p, input logic [31:0] ex);
      logic [31:0] d;
      wb(1, REG_CMD, {16'h0, id}, d);
      wb(1, REG_TGT, {16'h0, tg}, d);
      wb(1, REG_PAY, p, d);
      wb(1, REG_CTRL, 32'h1, d);
      d = 0;
      for (int i = 0; i < 20 && d[STAT_DONE] !== 1'b1; i++)
         wb(0, REG_CTRL, 0, d);
      chk(d[STAT_ERR], tg != UNIT_ADDR);
      wb(0, REG_RSP_ID, 0, d);
      chk(d[15:0], id | RSP_FLAG);
      wb(0, REG_RSP_TGT, 0, d);
      chk(d[15:0], tg);
      wb(0, REG_RSP_PAY, 0, d);
      chk(d, ex);
      wb(1, REG_CTRL, 32'h2, d);
   endtask : run
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      logic [31:0] d, p;
      rst = 1;
      {wb_cyc_i, wb_stb_i, wb_we_i, upset} = 0;
      {wb_adr_i, wb_dat_i} = 0;
      wb_sel_i = 4'hf;
      seed = 32'h06c2;
      repeat (3) @(posedge clock);
      rst <= 0;
      // masks set before they are read back
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         p = {k < 2 ? 4'h8 : 4'(k), 12'h0, seed[15:0]};
         run(k[0] ? CMD_MASK_HI_SET : CMD_MASK_LO_SET, UNIT_ADDR, p,
            p);
         for (int b = 0; b < 8; b++) begin
            if ((k < 2 || b == k) && k[0]) hi_m[b] = seed[15:0];
            if ((k < 2 || b == k) && !k[0]) lo_m[b] = seed[15:0];
         end
      end
      run(CMD_MASK_LO_SET, UNIT_ADDR, 32'h90001234,
         32'hf0001234);
      for (int b = 0; b < 10; b++) begin
         run(CMD_MASK_LO_RD, UNIT_ADDR, {4'(b), 28'h0}, b > 7 ? PAY_BADBRD
            : {4'(b), 12'h0, 16'(lo_m[b % 8])});
         run(CMD_MASK_HI_RD, UNIT_ADDR, {4'(b), 28'h0}, b > 7 ? PAY_BADBRD
            : {4'(b), 12'h0, 16'(hi_m[b % 8])});
      end
      upset <= 1;
      run(CMD_MASK_LO_RD, UNIT_ADDR, 32'h30000000, PAY_ONES);
      upset <= 0;
      run(CMD_FIFO_CLR, 16'h4001, 32'h00010101,
         32'h00010101);
      run(CMD_FIFO_CLR, UNIT_ADDR, 32'h0, 32'h0);
      {hb, hi, hm} = 0;
      run(CMD_FIFO_CLR, UNIT_ADDR, 32'h00020103,
         32'h00020103);
      repeat (40) @(posedge clock);
      chk(hb, 8);
      chk(hi, 4);
      chk(hm, 12);
      {hb, hi, hm} = 0;
      run(CMD_FIFO_CLR, UNIT_ADDR, 32'h00f0f0f0,
         32'h00f0f0f0);
      repeat (1000) @(posedge clock);
      chk(hb, 960);
      chk(hi, 960);
      chk(hm, 960);
      {nw, na} = 0;
      run(CMD_SAW, UNIT_ADDR, 32'h20000003, 32'h20000003);
      repeat (50) @(posedge clock);
      chk(nw, 3);
      chk(na, 24);
      chk(saw_board, 3'h2);
      run(CMD_SAW, UNIT_ADDR, 32'h80000003,
         ep(CMD_SAW, 32'h80000003));
      run(CMD_DAC_INIT, UNIT_ADDR, 32'h80000000,
         32'h80000000);
      chk(ini_q, 8'hff);
      run(CMD_DAC_INIT, UNIT_ADDR, 32'h5e000000,
         32'h5e000000);
      chk(ini_q, 8'h20);
      for (int t = 0; t < 4; t++) begin
         p = {4'h3, 5'h0, 2'(t), 1'b0, 4'h5, 16'h2150};
         run(CMD_DAC_SET, UNIT_ADDR, p, p);
         chk({type_q, all_q, chan_q}, {2'(t), t == 3,
            t == 3 ? 4'h0 : 4'h5});
         chk(code_q, {3'h3, 16'h2150});
      end
      foreach (vt[i]) begin
         p = {4'h1, 5'h0, vt[i][17:16], 5'h1, vt[i][15:0]};
         run(CMD_DAC_SET, UNIT_ADDR, p,
            ep(CMD_DAC_SET, p));
      end
      wb(0, 8'h20, 0, d);
      chk(d, 0);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
